// File: sbw_standby_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Mode register is 8 bits, reset 00.
// - Mode 00 light idle, 10 flash idle, x1 stop.
// - Flash idle keeps oscillator; wait before resuming.
// - Light idle keeps oscillator, PLL, flash running.
// - Stop halts everything except subclock oscillator.
// - Trigger bit enters mode chosen by field.
// - Selector sets stop and flash-idle waits.
// - Selector register resets to 06.
// - Selector 0..6 gives 2^10..2^16 cycles.
// - After reset wait 2^16 cycles.
// - Wait starts only after oscillator has started.
// - Mode register accessible as byte or bit.
// - Selector register accessed as whole byte.
module sbw_standby_ctrl #(
   parameter int WAIT_BASE_LOG2 = sbw_pkg::WAIT_BASE_LOG2,
   parameter int WAIT_CNT_W = sbw_pkg::WAIT_CNT_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic wake_req,
   input wire logic osc_started,
   output logic main_osc_en,
   output logic pll_en,
   output logic flash_en,
   output logic cpu_clk_en,
   output logic periph_clk_en
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   sbw_pkg::sbw_state_t state_reg;
   sbw_pkg::sbw_state_t state_next;

   logic [1:0] mode_sel_reg;
   logic [sbw_pkg::WAIT_SEL_W-1:0] wait_sel_reg;
   logic trigger_reg;

   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [31:0] addr_reg;
   logic [2:0] size_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   logic [31:0] hrdata_reg;

   logic main_osc_en_reg;
   logic pll_en_reg;
   logic flash_en_reg;
   logic cpu_clk_en_reg;
   logic periph_clk_en_reg;

   logic wait_start;
   logic trigger_clr;

   sbw_wait_if wait_bus();

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   // The counter must hold the longest documented wait, selector 6, and a
   // base of zero would make the shortest wait a single cycle.
   if (WAIT_BASE_LOG2 < 1 || WAIT_BASE_LOG2 + 6 > WAIT_CNT_W) begin : g_bad_params
      $error("sbw_standby_ctrl: WAIT_CNT_W too small for WAIT_BASE_LOG2");
   end

   // ------------------------------------------------------------
   // Wait counter
   // ------------------------------------------------------------
   sbw_wait_counter #(
      .BASE_LOG2(WAIT_BASE_LOG2),
      .CNT_W(WAIT_CNT_W)
   ) u_wait (
      .hclk(hclk),
      .hresetn(hresetn),
      .w(wait_bus)
   );

   // One selector serves both the stop and the flash-idle wait.
   assign wait_bus.start = wait_start;
   assign wait_bus.sel = wait_sel_reg;

   // ------------------------------------------------------------
   // Bus address phase
   // ------------------------------------------------------------
   wire addr_phase = hsel && hready && htrans[1];
   wire take_write = addr_phase && hwrite;
   wire take_read = addr_phase && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= '0;
         size_reg <= '0;
      end else begin
         wr_pend_reg <= take_write;
         if (addr_phase) begin
            addr_reg <= haddr;
            size_reg <= hsize;
         end
      end
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   // Registers live in byte lane 0; a byte or half-word write that does
   // not cover lane 0 leaves them untouched.
   wire lane0 = (addr_reg[1:0] == 2'h0) || (size_reg == sbw_pkg::HSIZE_WORD);
   wire hit_mode = addr_reg[31:2] == sbw_pkg::ADDR_MODE_SEL[31:2];
   wire hit_wait = addr_reg[31:2] == sbw_pkg::ADDR_WAIT_SEL[31:2];
   wire hit_pwr = addr_reg[31:2] == sbw_pkg::ADDR_PWR_CTRL[31:2];
   wire hit_stat = addr_reg[31:2] == sbw_pkg::ADDR_STATUS[31:2];

   wire wr_ok = wr_pend_reg && lane0;
   wire wr_mode = wr_ok && hit_mode;
   wire wr_wait = wr_ok && hit_wait;
   wire wr_pwr = wr_ok && hit_pwr;

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_sel_reg <= sbw_pkg::MODE_SEL_RESET[1:0];
         wait_sel_reg <= sbw_pkg::WAIT_SEL_RESET[sbw_pkg::WAIT_SEL_W-1:0];
      end else begin
         if (wr_mode) begin
            mode_sel_reg <= {hwdata[sbw_pkg::MODE_SEL_HI_BIT],
                             hwdata[sbw_pkg::MODE_SEL_LO_BIT]};
         end
         if (wr_wait) begin
            // Upper bits are expected zero and are not stored.
            wait_sel_reg <= hwdata[sbw_pkg::WAIT_SEL_W-1:0];
         end
      end
   end

   // A software write wins over the hardware clear in the same cycle,
   // so a fresh request is never lost.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trigger_reg <= sbw_pkg::PWR_CTRL_RESET[sbw_pkg::TRIGGER_BIT];
      end else if (wr_pwr) begin
         trigger_reg <= hwdata[sbw_pkg::TRIGGER_BIT];
      end else if (trigger_clr) begin
         trigger_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   wire [7:0] mode_rd = {6'h00, mode_sel_reg};
   wire [7:0] wait_rd = {5'h00, wait_sel_reg};
   wire run_now = state_reg == sbw_pkg::ST_RUN;
   logic [7:0] pwr_rd;
   logic [7:0] stat_rd;
   logic [7:0] rd_byte;

   // Control and status bytes are built from the named bit positions, so a
   // moved field needs no edit here.
   always_comb begin
      pwr_rd = 8'h00;
      pwr_rd[sbw_pkg::TRIGGER_BIT] = trigger_reg;
      stat_rd = 8'h00;
      stat_rd[sbw_pkg::STAT_RUN_BIT] = run_now;
      stat_rd[sbw_pkg::STAT_WAIT_BIT] = wait_bus.busy;
   end

   // Unmapped offsets read zero.
   always_comb begin
      rd_byte = 8'h00;
      if (hit_mode) begin
         rd_byte = mode_rd;
      end else if (hit_wait) begin
         rd_byte = wait_rd;
      end else if (hit_pwr) begin
         rd_byte = pwr_rd;
      end else if (hit_stat) begin
         rd_byte = stat_rd;
      end
   end

   // Reads take one wait state so that a write just before is seen.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend_reg <= 1'b0;
         hreadyout_reg <= 1'b1;
      end else begin
         rd_pend_reg <= take_read;
         if (take_read) begin
            hreadyout_reg <= 1'b0;
         end else if (rd_pend_reg) begin
            hreadyout_reg <= 1'b1;
         end
      end
   end

   // Read data hold until the next read completes.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= '0;
      end else if (rd_pend_reg) begin
         hrdata_reg <= {24'h000000, rd_byte};
      end
   end

   // The slave never signals an error; the flop keeps the output registered.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_reg <= 1'b0;
      end else begin
         hresp_reg <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;

   // ------------------------------------------------------------
   // Standby sequencer
   // ------------------------------------------------------------
   // Either code with the low bit set selects stop.
   wire mode_is_stop = mode_sel_reg[sbw_pkg::MODE_SEL_LO_BIT];
   wire mode_is_flash = mode_sel_reg == sbw_pkg::MODE_FLASH_IDLE;

   always_comb begin
      state_next = state_reg;
      wait_start = 1'b0;
      trigger_clr = 1'b0;
      case (state_reg)
         sbw_pkg::ST_OSC_START: begin
            // The count may only begin once the oscillator runs.
            if (osc_started) begin
               wait_start = 1'b1;
               state_next = sbw_pkg::ST_SETTLE;
            end
         end
         sbw_pkg::ST_SETTLE: begin
            if (wait_bus.done) begin
               trigger_clr = 1'b1;
               state_next = sbw_pkg::ST_RUN;
            end
         end
         sbw_pkg::ST_RUN: begin
            if (trigger_reg) begin
               if (mode_is_stop) begin
                  state_next = sbw_pkg::ST_STOP;
               end else if (mode_is_flash) begin
                  state_next = sbw_pkg::ST_FLASH_IDLE;
               end else begin
                  state_next = sbw_pkg::ST_LIGHT_IDLE;
               end
            end
         end
         sbw_pkg::ST_LIGHT_IDLE: begin
            // Oscillator and PLL never stopped, so no wait is needed.
            if (wake_req) begin
               trigger_clr = 1'b1;
               state_next = sbw_pkg::ST_RUN;
            end
         end
         sbw_pkg::ST_FLASH_IDLE: begin
            // PLL and flash restart together and share the setup count.
            if (wake_req) begin
               wait_start = 1'b1;
               state_next = sbw_pkg::ST_SETTLE;
            end
         end
         sbw_pkg::ST_STOP: begin
            // The oscillator restarts first; the count waits for it.
            if (wake_req) begin
               state_next = sbw_pkg::ST_OSC_START;
            end
         end
         default: begin
            state_next = sbw_pkg::ST_OSC_START;
         end
      endcase
   end

   // Reset enters the same path as a stop release, with selector 6.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= sbw_pkg::ST_OSC_START;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Clock and oscillator enables
   // ------------------------------------------------------------
   wire next_run = state_next == sbw_pkg::ST_RUN;
   wire next_stop = state_next == sbw_pkg::ST_STOP;
   wire next_flash = state_next == sbw_pkg::ST_FLASH_IDLE;
   // Light idle keeps PLL and flash up; flash idle keeps only the oscillator.
   wire main_osc_en_next = !next_stop;
   wire pll_en_next = !(next_stop || next_flash);
   wire flash_en_next = !(next_stop || next_flash);
   wire clk_en_next = next_run;

   // Enables are registered from the next state so each one changes in
   // the same cycle as the state itself.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         main_osc_en_reg <= 1'b1;
         pll_en_reg <= 1'b1;
         flash_en_reg <= 1'b1;
         cpu_clk_en_reg <= 1'b0;
         periph_clk_en_reg <= 1'b0;
      end else begin
         main_osc_en_reg <= main_osc_en_next;
         pll_en_reg <= pll_en_next;
         flash_en_reg <= flash_en_next;
         cpu_clk_en_reg <= clk_en_next;
         periph_clk_en_reg <= clk_en_next;
      end
   end

   assign main_osc_en = main_osc_en_reg;
   assign pll_en = pll_en_reg;
   assign flash_en = flash_en_reg;
   assign cpu_clk_en = cpu_clk_en_reg;
   assign periph_clk_en = periph_clk_en_reg;

endmodule

// File: sbw_pkg.sv
package sbw_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [31:0] ADDR_WAIT_SEL = 32'hFFFFF6C0;
   localparam logic [31:0] ADDR_MODE_SEL = 32'hFFFFF820;
   localparam logic [31:0] ADDR_PWR_CTRL = 32'hFFFFF1FC;
   localparam logic [31:0] ADDR_STATUS = 32'hFFFFF1F8;

   // ------------------------------------------------------------
   // Reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_SEL_RESET = 8'h00;
   localparam logic [7:0] WAIT_SEL_RESET = 8'h06;
   localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
   localparam int MODE_SEL_LO_BIT = 0;
   localparam int MODE_SEL_HI_BIT = 1;
   localparam int TRIGGER_BIT = 1;
   localparam int WAIT_SEL_W = 3;
   localparam int STAT_RUN_BIT = 0;
   localparam int STAT_WAIT_BIT = 1;

   // ------------------------------------------------------------
   // Mode field codes and wait timing
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_LIGHT_IDLE = 2'h0;
   localparam logic [1:0] MODE_FLASH_IDLE = 2'h2;
   localparam int WAIT_BASE_LOG2 = 10;
   localparam int WAIT_CNT_W = 17;

   // ------------------------------------------------------------
   // Bus encodings
   // ------------------------------------------------------------
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [2:0] {
      ST_OSC_START,
      ST_SETTLE,
      ST_RUN,
      ST_LIGHT_IDLE,
      ST_FLASH_IDLE,
      ST_STOP
   } sbw_state_t;

endpackage

// File: sbw_wait_if.sv
`timescale 1ns/1ps
interface sbw_wait_if;
   logic start;
   logic [sbw_pkg::WAIT_SEL_W-1:0] sel;
   logic busy;
   logic done;
   modport ctrl(output start, output sel, input busy, input done);
   modport cnt(input start, input sel, output busy, output done);
endinterface

// File: sbw_wait_counter.sv
`timescale 1ns/1ps
module sbw_wait_counter #(
   parameter int BASE_LOG2 = sbw_pkg::WAIT_BASE_LOG2,
   parameter int CNT_W = sbw_pkg::WAIT_CNT_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   sbw_wait_if.cnt w
);

   // The longest step, selector 6, must fit the counter.
   if (BASE_LOG2 < 1 || BASE_LOG2 + 6 > CNT_W) begin : g_bad_width
      $error("sbw_wait_counter: CNT_W too small for BASE_LOG2");
   end

   logic [CNT_W-1:0] cnt_reg;
   logic busy_reg;
   logic done_reg;
   wire [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};
   wire [CNT_W-1:0] load_val = (one << (BASE_LOG2 + int'(w.sel))) - one;
   wire at_end = busy_reg && (cnt_reg == '0);

   // A start loads 2^(BASE+sel)-1, so busy lasts exactly 2^(BASE+sel) cycles.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= at_end;
         if (w.start) begin
            cnt_reg <= load_val;
            busy_reg <= 1'b1;
         end else if (at_end) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg - one;
         end
      end
   end

   assign w.busy = busy_reg;
   assign w.done = done_reg;

endmodule

// File: sbw_standby_ctrl_assertions.sv
`timescale 1ns/1ps
module sbw_standby_ctrl_assertions #(
   parameter int WAIT_BASE_LOG2 = sbw_pkg::WAIT_BASE_LOG2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic osc_started,
   input wire logic main_osc_en,
   input wire logic pll_en,
   input wire logic flash_en,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en
);
   // ------------------------------------------------------------
   // Oscillator run time, saturating so long runs cannot wrap
   // ------------------------------------------------------------
   logic [19:0] osc_cnt_reg;
   logic take;
   assign take = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_cnt_reg <= 20'h00000;
      end else if (!main_osc_en || !osc_started) begin
         osc_cnt_reg <= 20'h00000;
      end else if (osc_cnt_reg != 20'hFFFFF) begin
         osc_cnt_reg <= osc_cnt_reg + 20'h00001;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   a_run_clocks_on: assert property (cpu_clk_en |-> main_osc_en && pll_en && flash_en)
      else $error("run without sources");
   a_pll_flash_pair: assert property (pll_en == flash_en)
      else $error("pll and flash differ");
   a_cpu_periph_pair: assert property (cpu_clk_en == periph_clk_en)
      else $error("cpu and peripheral clocks differ");
   a_stop_all_off: assert property (!main_osc_en |-> !pll_en && !cpu_clk_en)
      else $error("stop leaves circuits running");
   a_osc_wait_min: assert property (
      $rose(cpu_clk_en) |-> osc_cnt_reg >= (20'h00001 << WAIT_BASE_LOG2))
      else $error("clocks released before settle wait");
endmodule

// File: sbw_standby_ctrl_tb_top.sv
`timescale 1ns/1ps
module sbw_standby_ctrl_tb_top;
   localparam int B = 2;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, wake_req, osc_started;
   logic [1:0] htrans;
   logic [2:0] hsize, sel;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic main_osc_en, pll_en, flash_en, cpu_clk_en, periph_clk_en;
   int n_errors, samples_checked, cyc, n, w;

   sbw_standby_ctrl #(.WAIT_BASE_LOG2(B)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .wake_req(wake_req), .osc_started(osc_started), .main_osc_en(main_osc_en),
      .pll_en(pll_en), .flash_en(flash_en), .cpu_clk_en(cpu_clk_en),
      .periph_clk_en(periph_clk_en));

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   // ------------------------------------------------------------
   // Expectations and shared tasks
   // ------------------------------------------------------------
   function automatic int wait_len(input logic [2:0] s);
      return 1 << (B + int'(s));
   endfunction
   // Enables as {oscillator, pll, flash, cpu or peripheral clock}.
   function automatic logic [31:0] mode_en(input logic [1:0] m);
      return m[0] ? 32'h0 : (m[1] ? 32'h8 : 32'hE);
   endfunction
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Bus waits have no limit of their own (wait_run stops after 2000 cycles); the bench timeout ends a hang.
   task bus(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         @(posedge hclk);
      end
      r = hrdata;
   endtask
   task wait_run;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 2000) begin
         @(posedge hclk);
         n++;
      end
   endtask

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_errors++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(83));
      {hresetn, hsel, hwrite, wake_req, osc_started, htrans} = 7'h00;
      {haddr, hwdata} = 64'h0;
      hsize = sbw_pkg::HSIZE_WORD;
      {n_errors, samples_checked, cyc} = {32'h0, 32'h0, 32'h0};
      repeat (20) @(posedge hclk);
      check("rst_en", {main_osc_en, pll_en, flash_en, cpu_clk_en}, 32'hE);
      hresetn <= 1'b1;
      // The count must not start while the oscillator is still silent.
      bus(sbw_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
      check("stat_osc", rd, 32'h0);
      osc_started <= 1'b1;
      wait_run();
      check("rst_wait", 32'(n >= wait_len(3'h6) && n <= wait_len(3'h6) + 8), 32'h1);
      bus(sbw_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
      check("stat_run", rd, 32'h1 << sbw_pkg::STAT_RUN_BIT);
      bus(sbw_pkg::ADDR_MODE_SEL, 1'b0, 32'h0, rd);
      check("mode_rst", rd, {24'h0, sbw_pkg::MODE_SEL_RESET});
      bus(sbw_pkg::ADDR_WAIT_SEL, 1'b0, 32'h0, rd);
      check("sel_rst", rd, {24'h0, sbw_pkg::WAIT_SEL_RESET});
      bus(32'hFFFFF000, 1'b1, 32'hFF, rd);
      bus(32'hFFFFF000, 1'b0, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         sel = (i == 0) ? 3'h0 : (i == 1) ? 3'h6 : 3'($urandom % 7);
         bus(sbw_pkg::ADDR_WAIT_SEL, 1'b1, {29'h0, sel}, rd);
         bus(sbw_pkg::ADDR_WAIT_SEL, 1'b0, 32'h0, rd);
         check("sel_rw", rd, {29'h0, sel});
         bus(sbw_pkg::ADDR_MODE_SEL, 1'b1, {30'h0, 2'(i)}, rd);
         bus(sbw_pkg::ADDR_MODE_SEL, 1'b0, 32'h0, rd);
         check("mode_rw", rd, {30'h0, 2'(i)});
         bus(sbw_pkg::ADDR_PWR_CTRL, 1'b1, 32'h2, rd);
         repeat (3) @(posedge hclk);
         check("mode_en", {main_osc_en, pll_en, flash_en, cpu_clk_en | periph_clk_en},
            mode_en(2'(i)));
         // A stopped oscillator reports not started until the release.
         if (i % 2 == 1) osc_started <= 1'b0;
         @(posedge hclk);
         wake_req <= 1'b1;
         if (i % 2 == 1) begin
            repeat (6) @(posedge hclk);
            osc_started <= 1'b1;
         end
         wait_run();
         w = (i % 4 == 0) ? 0 : wait_len(sel);
         check("wake_wait", 32'(n >= w && n <= w + 8), 32'h1);
         wake_req <= 1'b0;
         bus(sbw_pkg::ADDR_PWR_CTRL, 1'b0, 32'h0, rd);
         check("trig_clr", {31'h0, rd[sbw_pkg::TRIGGER_BIT]}, 32'h0);
      end
      complete_run();
   end
endmodule

bind sbw_standby_ctrl sbw_standby_ctrl_assertions #(.WAIT_BASE_LOG2(WAIT_BASE_LOG2)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .osc_started(osc_started),
   .main_osc_en(main_osc_en), .pll_en(pll_en), .flash_en(flash_en),
   .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en));
